/* File: include/qrpt_pkg.sv */
// Constants shared by the quad reload PWM timer control block.
// Assumes an 8-bit register port on one 40 MHz system clock.
package qrpt_pkg;

  // ****************************************************************
  // Register offsets on the 8-bit register port
  // ****************************************************************
  localparam logic [7:0] QRPT_CTRL_ADDR  = 8'h00_C8; // Flags and runs.
  localparam logic [7:0] QRPT_MODE0_ADDR = 8'h00_C9; // Units A and B.
  localparam logic [7:0] QRPT_MODE1_ADDR = 8'h00_CA; // Units C and D.
  localparam logic [7:0] QRPT_STAT_ADDR  = 8'h00_E0; // Sticky events.
  localparam logic [7:0] QRPT_MASK_ADDR  = 8'h00_E1; // Event mask.
  // Reload byte addresses, one per unit, A first.
  localparam logic [7:0] QRPT_LOW_ADDR  [4] =
    '{8'h00_CC, 8'h00_CE, 8'h00_D4, 8'h00_D6};
  localparam logic [7:0] QRPT_HIGH_ADDR [4] =
    '{8'h00_CD, 8'h00_CF, 8'h00_D5, 8'h00_D7};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         QRPT_FLAG_POS   = 4;       // Flag nibble base.
  localparam int         QRPT_RUN_POS    = 0;       // Run nibble base.
  localparam int         QRPT_MODE_POS   = 3;       // Mode bit in nibble.
  localparam logic [7:0] QRPT_CTRL_RST   = 8'h00_00;
  localparam logic [7:0] QRPT_MODE_RST   = 8'h00_00;
  localparam logic [7:0] QRPT_RELOAD_RST = 8'h00_00;
  localparam logic [3:0] QRPT_MASK_RST   = 4'h0;

  // ****************************************************************
  // Operating modes and prescale divisors
  // ****************************************************************
  typedef enum logic { QRPT_AUTO_RELOAD, QRPT_PWM } qrpt_mode_t;

  // Prescale code to divide count minus one.
  function automatic logic [9:0] qrpt_div_limit(input logic [2:0] sel);
    logic [9:0] lim;
    lim = 10'h000;
    case (sel)
      3'h0:    lim = 10'h000;
      3'h1:    lim = 10'h001;
      3'h2:    lim = 10'h007;
      3'h3:    lim = 10'h00F;
      3'h4:    lim = 10'h03F;
      3'h5:    lim = 10'h07F;
      3'h6:    lim = 10'h1FF;
      default: lim = 10'h3FF;
    endcase
    return lim;
  endfunction : qrpt_div_limit

endpackage : qrpt_pkg

/* File: include/qrpt_tick_if.sv */
// Link between one timer unit and its prescaler.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
interface qrpt_tick_if;
  logic       run;  // Prescaler may count.
  logic [2:0] sel;  // Prescale code.
  logic       tick; // One-cycle count enable.
  modport ctrl  (output run, output sel, input tick);
  modport presc (input run, input sel, output tick);
endinterface : qrpt_tick_if

/* File: hdl/qrpt_prescaler.sv */
// Clock divider giving one count enable pulse per prescale period.
// Assumes run and select are stable while counting.
`timescale 1ns/10ps
module qrpt_prescaler
  import qrpt_pkg::*;
#(
  parameter int CNT_W = 10
)(
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  qrpt_tick_if.presc  tk
);

  // The largest divisor needs ten bits.
  if (CNT_W < 10)
  begin : g_chk
    $error("qrpt_prescaler: CNT_W must be at least 10");
  end

  logic [CNT_W-1:0] div_cnt; // Cycles since the last pulse.
  logic [9:0]       limit;   // Terminal count for the code.

  assign limit   = qrpt_div_limit(tk.sel);
  assign tk.tick = tk.run && (div_cnt >= CNT_W'(limit));

  // Count cycles while running, restart from zero when stopped.
  // Independent system-clock divider
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt <= '0;
    else if (!tk.run || tk.tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + CNT_W'(1);
  end

endmodule : qrpt_prescaler

/* File: hdl/qrpt_irq.sv */
// Sticky event status, mask and one level interrupt.
// Assumes events are one-cycle pulses on the system clock.
`timescale 1ns/10ps
module qrpt_irq
  import qrpt_pkg::*;
#(
  parameter int N = 4
)(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] events,
  input  wire logic         stat_rd,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);

  // Read clears, but an event in that very cycle is kept.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      status <= '0;
    else
      status <= (stat_rd ? '0 : status) | events;
  end

  // Mask register written by software.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask <= QRPT_MASK_RST[N-1:0];
    else if (mask_wr)
      mask <= mask_wdata;
  end

  // Level output, high while any unmasked bit stands.
  assign irq = |(status & mask);

endmodule : qrpt_irq

/* File: hdl/qrpt_top.sv */
// Four independent down-counting timers with register port.
// Assumes the register master is on sys_clk and never waits.
// Service-entry pulses come from the same clock domain.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module qrpt_top
  import qrpt_pkg::*;
#(
  parameter int N_UNITS = 4
)(
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire logic               bit_wr,
  input  wire logic [2:0]         bit_sel,
  input  wire logic               bit_val,
  input  wire logic [N_UNITS-1:0] isr_enter,
  output logic      [N_UNITS-1:0] unit_primary_out,
  output logic      [N_UNITS-1:0] unit_inverse_out,
  output logic                    irq
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************

  // The register layout holds exactly four units.
  if (N_UNITS != 4)
  begin : g_chk
    $error("qrpt_top: N_UNITS must be 4");
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic rst_meta; // First stage, read only by the second.
  logic rst_n;    // Released reset used by all logic.

  // Assert at once, release two edges after resetn rises.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************

  logic [N_UNITS-1:0] unit_expiry_flag; // Expiry flags, A at bit 0.
  logic [N_UNITS-1:0] unit_run;         // Run bits, A at bit 0.
  logic [7:0]         mode_lower_pair;  // Units A and B.
  logic [7:0]         mode_upper_pair;  // Units C and D.
  logic [7:0]         unit_reload_low  [N_UNITS]; // Low duty bytes.
  logic [7:0]         unit_reload_high [N_UNITS]; // High duty bytes.
  logic [N_UNITS-1:0] unit_mode_sel;    // One means PWM.
  logic [2:0]         unit_prescale [N_UNITS]; // Prescale codes.
  logic [N_UNITS-1:0] expire;           // One-cycle expiry events.
  logic [N_UNITS-1:0] irq_status;       // Sticky event copies.
  logic [N_UNITS-1:0] irq_mask;         // Interrupt mask.
  logic               ctrl_wr;          // Whole control write.
  logic               ctrl_bit_wr;      // Single control bit write.
  logic [15:0]        mode_both;        // Both mode registers, A lowest.

  assign ctrl_wr     = reg_wr && (reg_addr == QRPT_CTRL_ADDR);
  assign ctrl_bit_wr = bit_wr;

  // Join both mode registers so every unit owns one nibble of a
  // single vector; no index can then fall outside its register.
  assign mode_both = {mode_upper_pair, mode_lower_pair};

  // Unpack the joined mode registers into per-unit fields.
  // Each nibble holds the prescale code low and the mode bit high.
  always_comb
  begin
    for (int i = 0; i < N_UNITS; i++)
    begin
      unit_mode_sel[i] = mode_both[4*i + QRPT_MODE_POS];
      unit_prescale[i] = mode_both[4*i +: 3];
    end
  end

  // ****************************************************************
  // Control register: expiry flags and run bits
  // ****************************************************************

  // Run bits follow byte writes and single-bit writes.
  // Run nibble, bitwise
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_run <= QRPT_CTRL_RST[QRPT_RUN_POS +: 4];
    else if (ctrl_wr)
      unit_run <= reg_wdata[QRPT_RUN_POS +: 4];
    else if (ctrl_bit_wr && !bit_sel[2])
      unit_run[bit_sel[1:0]] <= bit_val;
  end

  // Flags: service clear first, then software, then hardware set.
  // Ordering this way keeps an expiry that meets any clear.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_expiry_flag <= QRPT_CTRL_RST[QRPT_FLAG_POS +: 4];
    else
    begin
      for (int i = 0; i < N_UNITS; i++)
      begin
        if (isr_enter[i] && (unit_mode_sel[i] == QRPT_AUTO_RELOAD))
          unit_expiry_flag[i] <= 1'b0;
        if (ctrl_wr)
          unit_expiry_flag[i] <= reg_wdata[QRPT_FLAG_POS + i];
        else if (ctrl_bit_wr && bit_sel[2] && (bit_sel[1:0] == i))
          unit_expiry_flag[i] <= bit_val;
        if (expire[i])
          unit_expiry_flag[i] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Mode and reload registers
  // ****************************************************************

  // Mode and prescale are taken as written; software keeps them
  // still while a unit runs, so no guard is spent here.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_lower_pair <= QRPT_MODE_RST;
      mode_upper_pair <= QRPT_MODE_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == QRPT_MODE0_ADDR)
        mode_lower_pair <= reg_wdata;
      if (reg_addr == QRPT_MODE1_ADDR)
        mode_upper_pair <= reg_wdata;
    end
  end

  // Reload bytes; a write while running is accepted as is, and
  // only takes effect when that unit next loads from that byte.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < N_UNITS; i++)
      begin
        unit_reload_low[i]  <= QRPT_RELOAD_RST;
        unit_reload_high[i] <= QRPT_RELOAD_RST;
      end
    end
    else if (reg_wr)
    begin
      for (int i = 0; i < N_UNITS; i++)
      begin
        if (reg_addr == QRPT_LOW_ADDR[i])
          unit_reload_low[i] <= reg_wdata;
        if (reg_addr == QRPT_HIGH_ADDR[i])
          unit_reload_high[i] <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // Timer units
  // ****************************************************************

  for (genvar u = 0; u < N_UNITS; u++)
  begin : g_unit
    qrpt_tick_if  tk ();       // Prescaler link.
    logic         run_q;       // Run bit one cycle ago.
    logic         start;       // First running cycle.
    logic [15:0]  count;       // Down counter.
    logic         phase_high;  // PWM is in its high part.
    logic         out_level;   // Primary output level.
    logic         hit;         // Underflow or PWM match at one.
    logic [15:0]  reload_word; // Joined reload value.

    assign reload_word = {unit_reload_high[u], unit_reload_low[u]};
    assign start       = unit_run[u] && !run_q;
    // Counting starts the cycle after the load.
    assign tk.run      = unit_run[u] && run_q;
    assign tk.sel      = unit_prescale[u];

    qrpt_prescaler #(
      .CNT_W (10)
    ) u_presc (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tk      (tk)
    );

    // Auto-reload underflows from zero; PWM matches when the low byte reaches one.
    always_comb
    begin
      if (unit_mode_sel[u] == QRPT_PWM)
        hit = (count[7:0] <= 8'h01);
      else
        hit = (count == 16'h0000);
    end

    assign expire[u] = tk.run && tk.tick && hit;

    // Remember the run bit to find its rising edge.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
        run_q <= 1'b0;
      else
        run_q <= unit_run[u];
    end

    // Counter, PWM phase and output level.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        count      <= 16'h0000;
        phase_high <= 1'b1;
        out_level  <= 1'b1;
      end
      else if (!unit_run[u])
      begin
        count      <= 16'h0000;
        phase_high <= 1'b1;
        out_level  <= 1'b1;
      end
      else if (start)
      begin
        phase_high <= 1'b1;
        out_level  <= 1'b1;
        if (unit_mode_sel[u] == QRPT_PWM)
          count <= {8'h00, unit_reload_high[u]};
        else
          count <= reload_word;
      end
      else if (tk.tick)
      begin
        if (!hit)
          count <= count - 16'h0001;
        else if (unit_mode_sel[u] == QRPT_PWM)
        begin
          count      <= phase_high ? {8'h00, unit_reload_low[u]}
                                   : {8'h00, unit_reload_high[u]};
          phase_high <= !phase_high;
          out_level  <= !out_level;
        end
        else
        begin
          count     <= reload_word;
          out_level <= !out_level;
        end
      end
    end

    assign unit_primary_out[u] = out_level;
    assign unit_inverse_out[u] = !out_level;
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************

  qrpt_irq #(
    .N (N_UNITS)
  ) u_irq (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .events     (expire),
    .stat_rd    (reg_rd && (reg_addr == QRPT_STAT_ADDR)),
    .mask_wr    (reg_wr && (reg_addr == QRPT_MASK_ADDR)),
    .mask_wdata (reg_wdata[N_UNITS-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Read data stand for the one cycle after the strobe, else zero.
  // Unmapped addresses read as zero.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00_00;
    else if (!reg_rd)
      reg_rdata <= 8'h00_00;
    else
    begin
      reg_rdata <= 8'h00_00;
      case (reg_addr)
        QRPT_CTRL_ADDR:  reg_rdata <= {unit_expiry_flag, unit_run};
        QRPT_MODE0_ADDR: reg_rdata <= mode_lower_pair;
        QRPT_MODE1_ADDR: reg_rdata <= mode_upper_pair;
        QRPT_STAT_ADDR:  reg_rdata <= {4'h0, irq_status};
        QRPT_MASK_ADDR:  reg_rdata <= {4'h0, irq_mask};
        default:
        begin
          // Reload bytes read back as stored.
          for (int i = 0; i < N_UNITS; i++)
          begin
            if (reg_addr == QRPT_LOW_ADDR[i])
              reg_rdata <= unit_reload_low[i];
            if (reg_addr == QRPT_HIGH_ADDR[i])
              reg_rdata <= unit_reload_high[i];
          end
        end
      endcase
    end
  end

endmodule : qrpt_top

/* File: sim/qrpt_props.sv */
// Port-level checker for the quad reload timer block.
// Assumes it is bound to qrpt_top and sees only its ports.
`timescale 1ns/10ps
module qrpt_props
  import qrpt_pkg::*;
#(
  parameter int N_UNITS = 4
)(
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               bit_wr,
  input wire logic [2:0]         bit_sel,
  input wire logic               bit_val,
  input wire logic [N_UNITS-1:0] isr_enter,
  input wire logic [N_UNITS-1:0] unit_primary_out,
  input wire logic [N_UNITS-1:0] unit_inverse_out,
  input wire logic               irq
);
  logic run_a; // Shadow of the unit A run bit.

  // Follow byte and bit writes so a toggle can be tied to running.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      run_a <= 1'b0;
    else if (reg_wr && reg_addr == QRPT_CTRL_ADDR)
      run_a <= reg_wdata[0];
    else if (bit_wr && bit_sel == 3'h0)
      run_a <= bit_val;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence flag_a_set_s;
    bit_wr && bit_sel == 3'h4 && bit_val;
  endsequence
  sequence quiet_s;
    !reg_wr && !bit_wr && !isr_enter[0];
  endsequence
  sequence ctrl_rd_s;
    reg_rd && reg_addr == QRPT_CTRL_ADDR;
  endsequence

  inv_mirror_a: assert property (
    unit_inverse_out == ~unit_primary_out)
    else $error("inverse output differs");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00_00)
    else $error("read data outside read slot");
  stop_high_a: assert property (
    bit_wr && bit_sel == 3'h0 && !bit_val |-> ##[1:2] unit_primary_out[0])
    else $error("stopped unit not high");
  fall_run_a: assert property (
    $fell(unit_primary_out[0]) |-> $past(run_a))
    else $error("output moved while stopped");
  flag_set_a: assert property (
    flag_a_set_s ##1 quiet_s ##1 (quiet_s ##0 ctrl_rd_s) |=> reg_rdata[4])
    else $error("flag write lost");
  run_rd_a: assert property (
    (bit_wr && bit_sel == 3'h0) ##1 quiet_s ##1 ctrl_rd_s
      |=> reg_rdata[0] == $past(bit_val, 3))
    else $error("run bit read wrong");
  mask_off_a: assert property (
    reg_wr && reg_addr == QRPT_MASK_ADDR && reg_wdata[3:0] == 4'h0
      |=> !irq)
    else $error("masked interrupt high");
  reset_out_a: assert property (
    $rose(resetn) |-> (unit_primary_out == {N_UNITS{1'b1}} && !irq)[*2])
    else $error("outputs wrong after reset");
endmodule : qrpt_props

bind qrpt_top qrpt_props #(.N_UNITS(N_UNITS)) u_props (.sys_clk, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_wr, .bit_sel,
  .bit_val, .isr_enter, .unit_primary_out, .unit_inverse_out, .irq);

/* File: sim/test_qrpt.sv */
// Self-checking bench for the quad reload timer block.
// Assumes the checker is bound to the top module from its own file.
`timescale 1ns/10ps
module test_qrpt;
  import qrpt_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00_00;
  logic [7:0]  reg_wdata = 8'h00_00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata;
  logic        bit_wr    = 1'b0;
  logic [2:0]  bit_sel   = 3'h0;
  logic        bit_val   = 1'b0;
  logic [3:0]  isr_enter = 4'h0;
  logic [3:0]  unit_primary_out;
  logic [3:0]  unit_inverse_out;
  logic        irq;
  logic        rd_seen   = 1'b0;
  logic [7:0]  exp_q[$];            // Expected read data, oldest first.
  logic [15:0] seed      = 16'hF88F; // Start value of the xorshift.
  int          err_count = 0;
  int          tests_run = 0;
  int          n;
  // Every mapped place, then one unmapped address last.
  localparam logic [7:0] MAP [14] = '{8'h00_C8, 8'h00_C9, 8'h00_CA,
    8'h00_CC, 8'h00_CD, 8'h00_CE, 8'h00_CF, 8'h00_D4, 8'h00_D5,
    8'h00_D6, 8'h00_D7, 8'h00_E0, 8'h00_E1, 8'h00_F0};
  localparam int DIV [8] = '{1, 2, 8, 16, 64, 128, 512, 1024};

  qrpt_top uut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bit_wr, .bit_sel, .bit_val, .isr_enter,
    .unit_primary_out, .unit_inverse_out, .irq);

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] xs(input logic [15:0] x);
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction : xs

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The read slot is the cycle after the strobe, so compare mid-cycle.
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk)
  begin
    if (rd_seen)
      chk(reg_rdata, exp_q.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    exp_q.push_back(e);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge sys_clk);
    bit_wr  <= 1'b1;
    bit_sel <= s;
    bit_val <= v;
    @(posedge sys_clk);
    bit_wr <= 1'b0;
  endtask : bw

  task automatic isr(input logic [3:0] u);
    @(posedge sys_clk);
    isr_enter <= u;
    @(posedge sys_clk);
    isr_enter <= 4'h0;
  endtask : isr

  // Bounded wait for a unit output level; n counts the cycles taken.
  task automatic wait_lvl(input int u, input logic lvl);
    n = 0;
    while (unit_primary_out[u] !== lvl)
    begin
      @(negedge sys_clk);
      n++;
      if (n > 6000)
      begin
        err_count++;
        $display("mismatch at %0t got %h expected %h", $time, n, 6000);
        stop_test();
      end
    end
  endtask : wait_lvl

  task automatic measure(input int u, input int h, input int l);
    wait_lvl(u, 1'b0);
    wait_lvl(u, 1'b1);
    chk(16'(n), 16'(l));
    wait_lvl(u, 1'b0);
    chk(16'(n), 16'(h));
  endtask : measure

  // Reload and mode are written only while the unit is stopped.
  task automatic cfg(input int u, input logic m, input logic [2:0] ps,
                     input logic [7:0] hi, input logic [7:0] lo);
    wr(QRPT_HIGH_ADDR[u], hi);
    wr(QRPT_LOW_ADDR[u], lo);
    wr(u < 2 ? QRPT_MODE0_ADDR : QRPT_MODE1_ADDR,
       8'({m, ps}) << (4 * (u % 2)));
    bw(3'(u), 1'b1);
    chk(16'(unit_primary_out[u]), 16'h0001);
    chk(16'(unit_inverse_out[u]), 16'h0000);
  endtask : cfg

  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (MAP[i]) rd(MAP[i], 8'h00_00);
    $display("reset values done");
    for (int i = 1; i < 11; i++)
    begin
      seed = xs(seed);
      wr(MAP[i], seed[7:0]);
      rd(MAP[i], seed[7:0]);
    end
    wr(QRPT_CTRL_ADDR, {seed[11:8], 4'h0});
    rd(QRPT_CTRL_ADDR, {seed[11:8], 4'h0});
    $display("register access done");
    for (int s = 0; s < 8; s++)
    begin
      cfg(s % 4, 1'b1, 3'(s), 8'h00_03, 8'h00_02);
      measure(s % 4, 3 * DIV[s], 2 * DIV[s]);
      bw(3'(s % 4), 1'b0);
    end
    wr(QRPT_CTRL_ADDR, 8'h00_00);
    rd(QRPT_STAT_ADDR, 8'h00_0F);
    $display("prescale and pwm done");
    cfg(2, 1'b0, 3'h0, 8'h00_01, 8'h00_02);
    measure(2, 259, 259);
    wr(QRPT_MASK_ADDR, 8'h00_04);
    @(negedge sys_clk);
    chk(16'(irq), 16'h0001);
    rd(QRPT_CTRL_ADDR, 8'h00_44);
    isr(4'h4);
    rd(QRPT_CTRL_ADDR, 8'h00_04);
    rd(QRPT_STAT_ADDR, 8'h00_04);
    @(negedge sys_clk);
    chk(16'(irq), 16'h0000);
    $display("auto reload done");
    cfg(3, 1'b1, 3'h1, 8'h00_04, 8'h00_05);
    measure(3, 8, 10);
    isr(4'h8);
    rd(QRPT_CTRL_ADDR, 8'h00_8C);
    bw(3'h3, 1'b0);
    bw(3'h7, 1'b0);
    rd(QRPT_CTRL_ADDR, 8'h00_04);
    chk(16'(unit_primary_out[3]), 16'h0001);
    bw(3'h2, 1'b0);
    repeat (300) @(posedge sys_clk);
    rd(QRPT_CTRL_ADDR, 8'h00_00);
    bw(3'h4, 1'b1);
    rd(QRPT_CTRL_ADDR, 8'h00_10);
    bw(3'h0, 1'b1);
    rd(QRPT_CTRL_ADDR, 8'h00_11);
    bw(3'h0, 1'b0);
    wr(QRPT_MASK_ADDR, 8'h00_00);
    wr(QRPT_CTRL_ADDR, 8'h00_00);
    $display("flags and stop done");
    stop_test();
  end
endmodule : test_qrpt
